// ===== rtl/adc_pkg.sv
// shared constants for the audio dsp core datapath and run control
// assumes one core clock; host reaches registers over a parallel port
package adc_pkg;
  // ---------------------------------------------------------------
  // register offsets and reset values
  // ---------------------------------------------------------------
  localparam logic [15:0] OFS_RUN_CMD   = 16'hf402; // core_run_command
  localparam logic [15:0] OFS_HALT_CMD  = 16'hf403; // core halt command
  localparam logic [15:0] OFS_RESTART   = 16'hf890; // software_restart_control
  localparam logic        RST_RESTART_N = 1'h1;     // soft reset released
  localparam logic        RST_RUN       = 1'h0;     // core stopped
  localparam int          CMD_BIT       = 0;        // control bit position

  // ---------------------------------------------------------------
  // timing: cycles per sample = core clock / frame rate
  // ---------------------------------------------------------------
  localparam int CORE_HZ_FULL = 294_912_000; // top speed grade
  localparam int CORE_HZ_SLOW = 147_456_000; // lower speed grade
  localparam int FRAME_HZ     = 48_000;      // nominal frame rate
  localparam int CYC_FULL     = CORE_HZ_FULL / FRAME_HZ;
  localparam int CYC_SLOW     = CORE_HZ_SLOW / FRAME_HZ;

  // ---------------------------------------------------------------
  // datapath widths and formats
  // ---------------------------------------------------------------
  localparam int W_WORD  = 32;  // 8.24 and 32.0 word
  localparam int W_FRAC  = 24;  // fraction bits of 8.24
  localparam int W_DBL   = 64;  // 8.56 multiplier operand
  localparam int W_ACC   = 80;  // 24.56 accumulator / alu
  localparam int W_LS    = 256; // load/store path
  localparam int W_SER   = 24;  // serial port sample
  localparam int N_ACC   = 16;  // mac registers
  localparam int N_AGEN  = 16;  // address generator regs
  localparam int N_MUL   = 4;   // multipliers
  localparam logic [31:0] LFSR_SEED = 32'h0000_0001;
  localparam logic [23:0] CLIP_POS  = 24'h7f_ffff;
  localparam logic [23:0] CLIP_NEG  = 24'h80_0000;

  // instruction codes
  typedef enum logic [3:0] {
    OP_NOP   = 4'h0, OP_MAC  = 4'h1, OP_ALU  = 4'h2, OP_LOAD = 4'h3,
    OP_STORE = 4'h4, OP_AGEN = 4'h5, OP_CLIP = 4'h6, OP_ACC  = 4'h7,
    OP_CLR   = 4'h8
  } adc_op_t;

  // accelerator functions
  typedef enum logic [2:0] {
    FN_DIV = 3'h0, FN_SQRT = 3'h1, FN_SHIFT = 3'h2, FN_LOG2 = 3'h3,
    FN_EXP2 = 3'h4, FN_SLEW = 3'h5, FN_RAND = 3'h6, FN_PASS = 3'h7
  } adc_fn_t;

  // 1.23 serial word into 8.24 with seven headroom bits
  function automatic logic [31:0] expand(input logic [23:0] s);
    expand = {{7{s[23]}}, s, 1'b0};
  endfunction

  // 8.24 to 1.23: drop top seven bits and the lsb, saturating
  function automatic logic [23:0] clip(input logic [31:0] v);
    if (v[31:24] == {8{v[31]}})
      clip = v[24:1];
    else
      clip = v[31] ? CLIP_NEG : CLIP_POS;
  endfunction
endpackage

// ===== rtl/adc_accel.sv
// hardware accelerators: divide, square root, shift, log2, exp2,
// slew and pseudorandom; one result a cycle after each request
`timescale 1ns/1ps
module adc_accel (
  input  wire logic        i_ref_clk, // core clock
  input  wire logic        i_rst_n,   // async reset, active low
  input  wire logic        i_clear,   // soft reset held
  input  wire logic        i_valid,   // request strobe
  input  adc_pkg::adc_fn_t i_fn,      // function select
  input  wire logic [31:0] i_x,       // 8.24 operand
  input  wire logic [31:0] i_y,       // second operand
  output logic      [31:0] o_result,  // 8.24 result
  output logic             o_valid    // result strobe
);
  typedef struct packed {
    logic [31:0] res;   // last result
    logic        vld;   // result strobe
    logic [31:0] slew;  // slew state
    logic [31:0] lfsr;  // noise state
  } adc_acc_st_t;

  adc_acc_st_t st_reg, st_next;

  // integer square root, bit by bit
  function automatic logic [27:0] isqrt(input logic [55:0] v);
    logic [55:0] r;
    logic [27:0] q;
    r = v;
    q = '0;
    for (int b = 27; b >= 0; b--)
    begin
      if ({28'h0, q | (28'h1 << b)} * {28'h0, q | (28'h1 << b)} <= r)
        q = q | (28'h1 << b);
    end
    isqrt = q;
  endfunction

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb
  begin
    logic signed [55:0] q;
    logic        [4:0]  p;
    logic signed [7:0]  e;
    logic        [31:0] m;
    st_next = st_reg;
    q = '0;
    p = '0;
    e = '0;
    m = '0;
    st_next.vld = i_valid;
    for (int i = 0; i < 32; i++)
      if (i_x[i]) p = 5'(i);
    if (i_valid)
    begin
      case (i_fn)
        adc_pkg::FN_DIV:
        begin
          // zero divisor saturates by sign
          if (i_y == '0)
            st_next.res = i_x[31] ? 32'h8000_0000 : 32'h7fff_ffff;
          else
          begin
            q = $signed({i_x, 24'h0}) / $signed({{24{i_y[31]}}, i_y});
            if (q > 56'sh7fff_ffff) st_next.res = 32'h7fff_ffff;
            else if (q < -56'sh8000_0000) st_next.res = 32'h8000_0000;
            else st_next.res = q[31:0];
          end
        end
        adc_pkg::FN_SQRT:
          st_next.res = i_x[31] ? '0 : {4'h0, isqrt({i_x, 24'h0})};
        adc_pkg::FN_SHIFT:
          st_next.res = i_y[5] ? 32'($signed(i_x) >>> (6'd0 - i_y[5:0]))
                               : i_x << i_y[4:0];
        adc_pkg::FN_LOG2:
        begin
          // linear mantissa between powers of two
          m = i_x << (5'd31 - p);
          st_next.res = (i_x[31] || i_x == '0) ? 32'h8000_0000
                      : {8'({3'h0, p} - 8'd24), m[30:7]};
        end
        adc_pkg::FN_EXP2:
        begin
          e = $signed(i_x[31:24]);
          m = {8'h01, i_x[23:0]};
          if (e > 8'sd6) st_next.res = 32'h7fff_ffff;
          else if (e >= 0) st_next.res = m << e[2:0];
          else st_next.res = m >> (8'd0 - e);
        end
        adc_pkg::FN_SLEW:
        begin
          // move toward target by at most one step
          if ($signed(st_reg.slew) < $signed(i_x))
            st_next.slew = ($signed(i_x - st_reg.slew) > $signed(i_y))
                         ? st_reg.slew + i_y : i_x;
          else
            st_next.slew = ($signed(st_reg.slew - i_x) > $signed(i_y))
                         ? st_reg.slew - i_y : i_x;
          st_next.res = st_next.slew;
        end
        adc_pkg::FN_RAND:
        begin
          st_next.lfsr = {st_reg.lfsr[30:0], st_reg.lfsr[31]
                         ^ st_reg.lfsr[21] ^ st_reg.lfsr[1] ^ st_reg.lfsr[0]};
          st_next.res = st_next.lfsr;
        end
        default:
          st_next.res = i_x;
      endcase
    end
    if (i_clear)
    begin
      st_next.slew = '0;
      st_next.lfsr = adc_pkg::LFSR_SEED;
      st_next.vld  = 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge i_ref_clk or negedge i_rst_n)
    if (!i_rst_n)
      st_reg <= '{res: '0, vld: 1'b0, slew: '0, lfsr: adc_pkg::LFSR_SEED};
    else
      st_reg <= st_next;

  assign o_result = st_reg.res;
  assign o_valid  = st_reg.vld;
endmodule // adc_accel

// ===== rtl/adc_core.sv
// fixed point audio core datapath with host run control
// assumes host register strobes and operands are synchronous to i_ref_clk
`timescale 1ns/1ps
// Contract
// - 6144 cycles per sample, 3072 lower grade
// - budget equals core clock over frame rate
// - four 8.56 by 8.24 multipliers
// - sixteen 80-bit mac registers, two accumulators
// - 256-bit single load/store path
// - two 80-bit alus in 24.56
// - sixteen circular address generator registers
// - audio, parameters and data in 8.24
// - 24-bit inputs widened with headroom bits
// - clip outputs to 24-bit 1.23
// - 8.24 is two's complement
// - logic signals are signed 32.0
// - divide, sqrt, shift, log, exp, slew, noise
// - start bit write starts the core
// - halt register stops the core
module adc_core #(
  parameter int CORE_HZ = adc_pkg::CORE_HZ_FULL, // core clock rate
  parameter int RAM_AW  = 8                      // load/store ram address width
) (
  input  wire logic          i_ref_clk,    // core clock
  input  wire logic          i_rst_n,      // async reset, active low
  input  wire logic [15:0]   i_reg_addr,   // register address
  input  wire logic [15:0]   i_reg_wdata,  // register write data
  input  wire logic          i_reg_wr,     // write strobe
  input  wire logic          i_reg_rd,     // read strobe
  output logic      [15:0]   o_reg_rdata,  // read data, next cycle
  input  wire logic [3:0]    i_rate_div,   // frame rate divisor
  input  wire logic          i_op_valid,   // instruction strobe
  input  adc_pkg::adc_op_t   i_op,         // instruction
  input  adc_pkg::adc_fn_t   i_fn,         // accelerator function
  input  wire logic [3:0]    i_idx_a,      // first register index
  input  wire logic [3:0]    i_idx_b,      // second register index
  input  wire logic [255:0]  i_mul_a,      // four 8.56 operands
  input  wire logic [127:0]  i_mul_b,      // four 8.24 operands
  input  wire logic [31:0]   i_word,       // 8.24 or 32.0 operand
  input  wire logic [255:0]  i_store_data, // store line
  input  wire logic [23:0]   i_ser_word,   // serial input sample
  input  wire logic          i_ser_valid,  // serial sample strobe
  output logic               o_op_ready,   // core accepts ops
  output logic               o_running,    // core running
  output logic               o_sample_tick,// frame boundary pulse
  output logic      [15:0]   o_budget,     // cycles per sample
  output logic      [255:0]  o_load_data,  // load line
  output logic               o_load_valid, // load strobe
  output logic      [79:0]   o_acc_word,   // accumulator at idx_a
  output logic      [23:0]   o_clip_data,  // clipped 1.23 sample
  output logic               o_clip_valid, // clipped sample strobe
  output logic      [31:0]   o_in_word,    // widened serial sample
  output logic      [31:0]   o_accel_res,  // accelerator result
  output logic               o_accel_valid // accelerator strobe
);
  // ---------------------------------------------------------------
  // types and elaboration checks
  // ---------------------------------------------------------------
  // full grade gives 6144, lower grade 3072
  localparam int CYC = CORE_HZ / adc_pkg::FRAME_HZ;

  if (CYC < 1 || CYC * 8 > 65535 || RAM_AW < 1 || RAM_AW > 15)
    $error("adc_core: unsupported CORE_HZ or RAM_AW");

  typedef logic signed [79:0] adc_acc_t; // 24.56 word

  typedef struct packed {
    logic                         run;     // core executing
    logic                         soft_n;  // soft reset released
    logic [15:0]                  cnt;     // cycles left in sample
    logic                         tick;    // frame boundary
    logic [15:0]                  rdata;   // read data
    adc_acc_t [15:0]              acc;     // mac registers
    logic [15:0][RAM_AW-1:0]      ptr;     // agen pointers
    logic [15:0][RAM_AW-1:0]      base;    // circular base
    logic [15:0][RAM_AW:0]        len;     // circular length
    logic [23:0]                  clip;    // clipped sample
    logic                         clip_v;  // clip strobe
    logic [31:0]                  inw;     // widened input
    logic                         ld_v;    // load strobe
    logic [79:0]                  accw;    // accumulator out
  } adc_st_t;

  adc_st_t st_reg, st_next;
  logic [255:0] ram [2**RAM_AW];  // data lines
  logic [255:0] ld_reg;           // load line out
  logic [15:0]  budget;           // cycles per sample
  logic         do_op;            // op accepted
  logic         wr_run, wr_halt, wr_soft;

  // 8.56 x 8.24 gives 16.80, aligned to 24.56
  function automatic adc_acc_t mul_term(input logic [63:0] a,
                                        input logic [31:0] b);
    logic signed [95:0] p;
    p = $signed(a) * $signed(b);
    mul_term = {{8{p[95]}}, p[95:24]};
  endfunction

  function automatic logic [RAM_AW-1:0] agen_step(
    input logic [RAM_AW-1:0] p, input logic [RAM_AW-1:0] b,
    input logic [RAM_AW:0] l);
    logic [RAM_AW:0] n;
    n = {1'b0, p} + 1'b1;
    if (l != '0 && n >= {1'b0, b} + l)
      agen_step = b;
    else
      agen_step = n[RAM_AW-1:0];
  endfunction

  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  // slower frame rate stretches the budget
  assign budget  = 16'(CYC) * ((i_rate_div == '0) ? 16'h1
                                                  : {12'h0, i_rate_div});
  assign wr_run  = i_reg_wr && i_reg_addr == adc_pkg::OFS_RUN_CMD;
  assign wr_halt = i_reg_wr && i_reg_addr == adc_pkg::OFS_HALT_CMD;
  assign wr_soft = i_reg_wr && i_reg_addr == adc_pkg::OFS_RESTART;
  // ops only while running; host keeps it stopped to reload
  assign do_op   = i_op_valid && st_reg.run && st_reg.soft_n;

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb
  begin
    st_next        = st_reg;
    st_next.tick   = 1'b0;
    st_next.clip_v = 1'b0;
    st_next.ld_v   = 1'b0;
    // run control: halt beats start in the same cycle
    // start on a one in bit 0
    if (wr_run && i_reg_wdata[adc_pkg::CMD_BIT])
      st_next.run = 1'b1;
    if (wr_halt && i_reg_wdata[adc_pkg::CMD_BIT])
      st_next.run = 1'b0;
    // bit 0 low holds the core in soft reset
    if (wr_soft)
      st_next.soft_n = i_reg_wdata[adc_pkg::CMD_BIT];
    // sample timer runs only with the core
    if (st_reg.run)
    begin
      if (st_reg.cnt == '0)
      begin
        st_next.cnt  = budget - 16'h1;
        st_next.tick = 1'b1;
      end
      else
        st_next.cnt = st_reg.cnt - 16'h1;
    end
    // register read data, unmapped reads zero
    if (i_reg_rd)
    begin
      case (i_reg_addr)
        adc_pkg::OFS_RUN_CMD: st_next.rdata = {15'h0, st_reg.run};
        adc_pkg::OFS_RESTART: st_next.rdata = {15'h0, st_reg.soft_n};
        default:              st_next.rdata = '0;
      endcase
    end
    if (i_ser_valid)
      st_next.inw = adc_pkg::expand(i_ser_word);
    if (do_op)
    begin
      case (i_op)
        // two accumulators share the sixteen registers
        adc_pkg::OP_MAC:
        begin
          st_next.acc[i_idx_a] = st_reg.acc[i_idx_a]
            + mul_term(i_mul_a[0+:64], i_mul_b[0+:32])
            + mul_term(i_mul_a[64+:64], i_mul_b[32+:32]);
          st_next.acc[i_idx_b] = st_reg.acc[i_idx_b]
            + mul_term(i_mul_a[128+:64], i_mul_b[64+:32])
            + mul_term(i_mul_a[192+:64], i_mul_b[96+:32]);
        end
        // two 80-bit alus as a sum/difference pair
        adc_pkg::OP_ALU:
        begin
          st_next.acc[i_idx_a] = st_reg.acc[i_idx_a] + st_reg.acc[i_idx_b];
          st_next.acc[i_idx_b] = st_reg.acc[i_idx_a] - st_reg.acc[i_idx_b];
        end
        adc_pkg::OP_LOAD, adc_pkg::OP_STORE:
        begin
          st_next.ld_v = (i_op == adc_pkg::OP_LOAD);
          st_next.ptr[i_idx_a] = agen_step(st_reg.ptr[i_idx_a],
                                 st_reg.base[i_idx_a], st_reg.len[i_idx_a]);
        end
        adc_pkg::OP_AGEN:
        begin
          st_next.ptr[i_idx_a]  = i_word[RAM_AW-1:0];
          st_next.base[i_idx_a] = i_word[RAM_AW-1:0];
          st_next.len[i_idx_a]  = i_word[16+:RAM_AW+1];
        end
        adc_pkg::OP_CLIP:
        begin
          st_next.clip   = adc_pkg::clip(i_word);
          st_next.clip_v = 1'b1;
        end
        // load a signed 8.24 or 32.0 word
        // 8.24 to 24.56: sixteen sign bits above, 32 zeros below
        adc_pkg::OP_CLR:
          st_next.acc[i_idx_a] = {{16{i_word[31]}}, i_word, 32'h0};
        default: ;
      endcase
      st_next.accw = st_next.acc[i_idx_a];
    end
    // soft reset clears datapath state, keeps run bit off
    if (!st_reg.soft_n)
    begin
      st_next.run  = 1'b0;
      st_next.cnt  = '0;
      st_next.acc  = '0;
      st_next.ptr  = '0;
      st_next.base = '0;
      st_next.len  = '0;
    end
  end

  // ---------------------------------------------------------------
  // state registers and ram
  // ---------------------------------------------------------------
  always_ff @(posedge i_ref_clk or negedge i_rst_n)
    if (!i_rst_n)
    begin
      st_reg        <= '0;
      st_reg.soft_n <= adc_pkg::RST_RESTART_N;
      st_reg.run    <= adc_pkg::RST_RUN;
    end
    else
      st_reg <= st_next;

  // no reset on the line store; it holds program data only
  always_ff @(posedge i_ref_clk)
    if (do_op && i_op == adc_pkg::OP_STORE)
      ram[st_reg.ptr[i_idx_a]] <= i_store_data;
    else if (do_op && i_op == adc_pkg::OP_LOAD)
      ld_reg <= ram[st_reg.ptr[i_idx_a]];

  // ---------------------------------------------------------------
  // accelerators
  // ---------------------------------------------------------------
  adc_accel u_accel (
    .i_ref_clk (i_ref_clk),
    .i_rst_n   (i_rst_n),
    .i_clear   (!st_reg.soft_n),
    .i_valid   (do_op && i_op == adc_pkg::OP_ACC),
    .i_fn      (i_fn),
    .i_x       (i_word),
    .i_y       (i_mul_b[31:0]),
    .o_result  (o_accel_res),
    .o_valid   (o_accel_valid)
  );

  assign o_reg_rdata   = st_reg.rdata;
  assign o_op_ready    = st_reg.run && st_reg.soft_n;
  assign o_running     = st_reg.run;
  assign o_sample_tick = st_reg.tick;
  assign o_budget      = budget;
  assign o_load_data   = st_reg.ld_v ? ld_reg : '0;
  assign o_load_valid  = st_reg.ld_v;
  assign o_acc_word    = st_reg.accw;
  assign o_clip_data   = st_reg.clip;
  assign o_clip_valid  = st_reg.clip_v;
  assign o_in_word     = st_reg.inw;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);

  logic [15:0] gap_cnt; // cycles since last tick
  logic [15:0] bud_q;   // budget one cycle ago
  logic        gap_ok;  // interval timed at one budget
  // a stop or a budget change spoils the interval being timed
  always_ff @(posedge i_ref_clk or negedge i_rst_n)
    if (!i_rst_n)
      {gap_cnt, bud_q, gap_ok} <= '0;
    else
    begin
      gap_cnt <= o_sample_tick ? 16'h1 : gap_cnt + 16'h1;
      bud_q   <= budget;
      gap_ok  <= o_running && budget == bud_q && (gap_ok || o_sample_tick);
    end

  sequence s_start_wr;
    wr_run && i_reg_wdata[0] && !wr_halt && !wr_soft && st_reg.soft_n;
  endsequence
  sequence s_halt_wr;
    wr_halt && i_reg_wdata[0];
  endsequence

  a_start_runs: assert property (s_start_wr |=> o_running)
    else $error("start write did not run core");
  a_halt_stops: assert property (s_halt_wr |=> !o_running)
    else $error("halt write did not stop core");
  a_soft_hold: assert property (wr_soft && !i_reg_wdata[0]
    |=> ##1 !o_running && !o_op_ready)
    else $error("soft reset did not hold core");
  a_tick_gap: assert property (o_sample_tick && gap_ok
    && budget == bud_q |-> gap_cnt == budget)
    else $error("sample tick spacing wrong");
  a_budget_val: assert property (i_rate_div == 4'h1
    |-> o_budget == 16'(CYC))
    else $error("budget not core clock over frame rate");
  a_clip_sat: assert property (do_op && i_op == adc_pkg::OP_CLIP
    && !i_word[31] && i_word[30:24] != '0
    |=> o_clip_valid && o_clip_data == 24'h7f_ffff)
    else $error("clip did not saturate high");
  a_in_widen: assert property (i_ser_valid
    |=> o_in_word[31:25] == {7{o_in_word[24]}} && o_in_word[0] == 1'b0)
    else $error("serial word not widened");
  a_load_strobe: assert property (do_op && i_op == adc_pkg::OP_LOAD
    ##1 !(do_op && i_op == adc_pkg::OP_LOAD) |-> o_load_valid ##1 !o_load_valid)
    else $error("load strobe not one cycle");
endmodule // adc_core

// ===== dv/adc_host_model.sv
// host model: drives the core's register port
// assumes tb_top calls acc(); one core clock
`timescale 1ns/1ps
module adc_host_model (
  input  wire logic        i_ref_clk, // core clock
  output logic      [15:0] o_addr,    // register address
  output logic      [15:0] o_wdata,   // write data
  output logic             o_wr,      // write strobe
  output logic             o_rd,      // read strobe
  input  wire logic [15:0] i_rdata    // read data
);
  initial
  begin
    {o_addr, o_wdata, o_wr, o_rd} = '0;
  end

  // host register cycles
  // one access a call; read data taken an edge later
  task automatic acc(input logic w, input logic [15:0] a,
                     input logic [15:0] d, output logic [15:0] q);
    @(posedge i_ref_clk);
    #1;
    o_addr = a;
    o_wdata = d;
    o_wr = w;
    o_rd = ~w;
    @(posedge i_ref_clk);
    #1;
    q = i_rdata;
    o_wr = 1'b0;
    o_rd = 1'b0;
    // idle bus shows the inverse so stale values never match
    o_addr = ~a;
    o_wdata = ~d;
  endtask
endmodule // adc_host_model

// ===== dv/tb_top.sv
// testbench for adc_core with a host model on its register port
// assumes CORE_HZ of 480000, so ten cycles per sample at divisor 1
`timescale 1ns/1ps
module tb_top;
  logic i_ref_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic [15:0] addr, wdata, rdata, budget, q;
  logic wr, rd, rdy, running, tick, clip_v, op_v = 0, ser_v = 0;
  logic [3:0] rate_div = 4'h1;
  adc_pkg::adc_op_t op = adc_pkg::OP_NOP;
  logic [31:0] word = '0, in_word;
  logic [23:0] ser = '0, clip;
  logic [79:0] acc;
  logic [255:0] st_line = {8{32'h0123_4567}}, ld;
  logic [31:0] ares;
  logic ld_v, a_v;
  adc_pkg::adc_fn_t fn = adc_pkg::FN_PASS;
  int n_mismatch = 0, check_count = 0, n;
  typedef struct packed {
    adc_pkg::adc_op_t op;
    logic [31:0] w;
    logic [79:0] e;
  } adc_row_t;
  // clip and clear cases: operand beside expected result
  adc_row_t rows [5] = '{
    '{adc_pkg::OP_CLIP, 32'h0080_0000, 80'h40_0000},
    '{adc_pkg::OP_CLIP, 32'h7fff_ffff, 80'h7f_ffff},
    '{adc_pkg::OP_CLIP, 32'h8000_0000, 80'h80_0000},
    '{adc_pkg::OP_CLIP, 32'hff00_0000, 80'h80_0000},
    '{adc_pkg::OP_CLR, 32'hff00_0000, 80'hffff_ff00_0000_0000_0000}};

  always #5 i_ref_clk = ~i_ref_clk;

  adc_host_model host (.i_ref_clk(i_ref_clk), .o_addr(addr),
    .o_wdata(wdata), .o_wr(wr), .o_rd(rd), .i_rdata(rdata));

  adc_core #(.CORE_HZ(480000)) dut (.i_ref_clk(i_ref_clk),
    .i_rst_n(i_rst_n), .i_reg_addr(addr), .i_reg_wdata(wdata),
    .i_reg_wr(wr), .i_reg_rd(rd), .o_reg_rdata(rdata),
    .i_rate_div(rate_div), .i_op_valid(op_v), .i_op(op),
    .i_fn(fn), .i_idx_a(4'h3), .i_idx_b(4'h5),
    .i_mul_a('0), .i_mul_b('0), .i_word(word), .i_store_data(st_line),
    .i_ser_word(ser), .i_ser_valid(ser_v), .o_op_ready(rdy),
    .o_running(running), .o_sample_tick(tick), .o_budget(budget),
    .o_load_data(ld), .o_load_valid(ld_v), .o_acc_word(acc),
    .o_clip_data(clip), .o_clip_valid(clip_v), .o_in_word(in_word),
    .o_accel_res(ares), .o_accel_valid(a_v));

  task automatic chk(input logic [79:0] got, input logic [79:0] exp);
    check_count++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // full load/store lines
  task automatic chk_line(input logic [255:0] got, input logic [255:0] exp);
    check_count++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks=%0d mismatches=%0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // one instruction; results settle before return
  task automatic do_op(input adc_pkg::adc_op_t o, input logic [31:0] w);
    @(posedge i_ref_clk);
    #1;
    op = o;
    word = w;
    op_v = 1'b1;
    @(posedge i_ref_clk);
    #1;
    op_v = 1'b0;
  endtask

  // cycles to the next tick, bounded
  task automatic wait_tick(output int c);
    c = 0;
    do
    begin
      @(posedge i_ref_clk);
      #1;
      c++;
    end while (tick !== 1'b1 && c < 200);
    if (c >= 200)
    begin
      n_mismatch++;
      tally_and_finish();
    end
  endtask

  initial
  begin
    repeat (12) @(posedge i_ref_clk);
    #1;
    i_rst_n = 1'b1;
    chk(running, 1'b0);
    host.acc(1'b0, adc_pkg::OFS_RESTART, '0, q);
    chk(q, 16'h1);
    do_op(adc_pkg::OP_CLIP, 32'h0080_0000);
    chk(clip_v, 1'b0);
    host.acc(1'b1, adc_pkg::OFS_RUN_CMD, 16'h1, q);
    chk(running, 1'b1);
    host.acc(1'b0, adc_pkg::OFS_RUN_CMD, '0, q);
    chk(q, 16'h1);
    host.acc(1'b0, adc_pkg::OFS_HALT_CMD, '0, q);
    chk(q, 16'h0);
    chk(budget, 16'd10);
    rate_div = 4'h3;
    #1;
    chk(budget, 16'd30);
    wait_tick(n);
    wait_tick(n);
    chk(n, 30);
    foreach (rows[i])
    begin
      do_op(rows[i].op, rows[i].w);
      if (rows[i].op == adc_pkg::OP_CLIP)
        chk({clip_v, clip}, {1'b1, rows[i].e[23:0]});
      else
        chk(acc, rows[i].e);
    end
    ser = 24'h80_0000;
    ser_v = 1'b1;
    @(posedge i_ref_clk);
    #1;
    ser_v = 1'b0;
    chk(in_word, 32'hff00_0000);
    host.acc(1'b1, adc_pkg::OFS_HALT_CMD, 16'h1, q);
    chk(running, 1'b0);
    do_op(adc_pkg::OP_CLIP, 32'h0080_0000);
    chk(clip_v, 1'b0);
    host.acc(1'b1, adc_pkg::OFS_RUN_CMD, 16'h1, q);
    host.acc(1'b1, adc_pkg::OFS_RESTART, 16'h0, q);
    host.acc(1'b1, adc_pkg::OFS_RUN_CMD, 16'h1, q);
    chk({running, rdy}, 2'b00);
    host.acc(1'b1, adc_pkg::OFS_RESTART, 16'h1, q);
    repeat (budget) @(posedge i_ref_clk);
    #1;
    host.acc(1'b1, adc_pkg::OFS_RUN_CMD, 16'h1, q);
    chk({running, rdy}, 2'b11);
    wait_tick(n);
    wait_tick(n);
    chk(n, 30);
    fn = adc_pkg::FN_SQRT;
    do_op(adc_pkg::OP_ACC, 32'h0400_0000);
    chk({a_v, ares}, {1'b1, 32'h0200_0000});
    fn = adc_pkg::FN_DIV;
    do_op(adc_pkg::OP_ACC, 32'h0100_0000);
    chk(ares, 32'h7fff_ffff);
    // base 0, length 1: the pointer wraps back onto itself
    do_op(adc_pkg::OP_AGEN, 32'h0001_0000);
    do_op(adc_pkg::OP_STORE, '0);
    do_op(adc_pkg::OP_LOAD, '0);
    chk(ld_v, 1'b1);
    chk_line(ld, st_line);
    // reset again in mid-run
    i_rst_n = 1'b0;
    repeat (2) @(posedge i_ref_clk);
    #1;
    i_rst_n = 1'b1;
    chk({running, rdy, ld_v, a_v, clip_v}, 5'h0);
    host.acc(1'b0, adc_pkg::OFS_RUN_CMD, '0, q);
    chk(q, 16'h0);
    tally_and_finish();
  end
endmodule // tb_top
